// *** common/sync_link_defs.vh ***
/*
  constants for the controller sync link block: register offsets, field
  positions, reset values and timing counts.
  assumes a 40 mhz logic clock and a 32-bit axi4-lite register bus.
*/
// Notes on behaviour
// - one leader per link, all others followers
// - leader launches only when everyone is ready
// - leader drives launch line to all participants
// - launch edge starts timers, strobe, camera trigger
// - go low until all ready; no launch
// - confirmed go high gives one falling edge
// - after start, pull go low until ready
// - own delay and width settings per device
// - launches at least 400 ns apart
// - disabled link runs cycles independently
`ifndef SYNC_LINK_DEFS_VH
`define SYNC_LINK_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REG_CTRL          4'h0
`define REG_STROBE_TIMING 4'h4
`define REG_TRIG_TIMING   4'h8
`define REG_STATUS        4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_LINK_EN_BIT  0
`define CTRL_LEADER_BIT   1
`define TIMING_DELAY_LSB  0
`define TIMING_WIDTH_LSB  16
`define STAT_GO_BIT       0
`define STAT_LAUNCH_BIT   1
`define STAT_RUN_BIT      2
`define STAT_HOLD_BIT     3
`define STAT_STATE_LSB    4
`define STAT_COUNT_LSB    16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RESET        2'h0
`define TIMING_RESET      32'h0004_0000

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     25
`define LAUNCH_SPACE_NS   400
`define LAUNCH_SPACE_CYC  ((`LAUNCH_SPACE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LAUNCH_LOW_NS     100
`define LAUNCH_LOW_CYC    ((`LAUNCH_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/link_pin_sync.v ***
/*
  three-stage synchroniser for asynchronous link pins, one per bit.
  assumes inputs may change at any time; output changes only once the
  second and third stages agree.
*/
module link_pin_sync #(
  parameter WIDTH = 2
) (
  // clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // pins in
  input  wire [WIDTH-1:0] pin_in,
  // settled levels out
  output wire [WIDTH-1:0] level_out
);

  // ----------------------------------------------------------------
  // per-bit stages
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg lvl_r;
      always @(posedge aclk) begin
        if (!aresetn) begin
          s1_r  <= 1'b1;
          s2_r  <= 1'b1;
          s3_r  <= 1'b1;
          lvl_r <= 1'b1;
        end else begin
          s1_r <= pin_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end
      assign level_out[i] = lvl_r;
    end
  endgenerate

endmodule // link_pin_sync

// *** rtl/sync_link_ctrl.v ***
/*
  controller sync link: readiness line, launch line, local strobe and
  camera trigger timers, axi4-lite register slave.
  assumes the go and launch lines are resolved outside from the output
  enables (go is open drain, pulled high), and local_ready comes from
  logic on aclk.
*/
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "sync_link_defs.vh"

module sync_link_ctrl #(
  parameter TW = 16
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // local start conditions
  input  wire        local_ready,
  // shared go line, open drain
  input  wire        go_in,
  output wire        go_out,
  output wire        go_oe,
  // shared launch line
  input  wire        launch_in,
  output reg         launch_out,
  output reg         launch_oe,
  // local outputs
  output reg         strobe_out,
  output reg         cam_trigger_out,
  output reg         cycle_start
);

  // ----------------------------------------------------------------
  // leader and local-cycle states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_DRIVE = 3'h1;
  localparam [2:0] ST_SPACE = 3'h2;
  localparam [2:0] ST_LOCAL = 3'h3;

  localparam integer SPACE_N = `LAUNCH_SPACE_CYC;
  localparam integer LOW_N   = `LAUNCH_LOW_CYC;
  localparam [4:0] SPACE_CYC = SPACE_N[4:0];
  localparam [4:0] LOW_CYC   = LOW_N[4:0];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [1:0]    ctrl_r;
  reg  [31:0]   strobe_tm_r;
  reg  [31:0]   trig_tm_r;
  reg  [15:0]   cycle_cnt_r;
  wire          link_en = ctrl_r[`CTRL_LINK_EN_BIT];
  wire          leader  = ctrl_r[`CTRL_LEADER_BIT];

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  reg  [3:0]    aw_addr_r;
  reg           aw_full_r;
  reg  [31:0]   w_data_r;
  reg  [3:0]    w_strb_r;
  reg           w_full_r;
  wire          do_write;
  wire          wr_hit;

  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_r && !s_axi_bvalid;
  assign do_write      = aw_full_r && w_full_r && !s_axi_bvalid;
  assign wr_hit        = (aw_addr_r == `REG_CTRL) ||
                         (aw_addr_r == `REG_STROBE_TIMING) ||
                         (aw_addr_r == `REG_TRIG_TIMING) ||
                         (aw_addr_r == `REG_STATUS);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_r    <= 4'h0;
      aw_full_r    <= 1'b0;
      w_data_r     <= 32'h0;
      w_strb_r     <= 4'h0;
      w_full_r     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      ctrl_r       <= `CTRL_RESET;
      strobe_tm_r  <= `TIMING_RESET;
      trig_tm_r    <= `TIMING_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= {s_axi_awaddr[3:2], 2'h0};
        aw_full_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_full_r <= 1'b1;
      end
      if (do_write) begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
        case (aw_addr_r)
          `REG_CTRL: begin
            if (w_strb_r[0]) begin
              ctrl_r <= w_data_r[1:0];
            end
          end
          `REG_STROBE_TIMING: begin
            strobe_tm_r <= merge(strobe_tm_r, w_data_r, w_strb_r);
          end
          `REG_TRIG_TIMING: begin
            trig_tm_r <= merge(trig_tm_r, w_data_r, w_strb_r);
          end
          default: begin
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // link pin synchronisers
  // ----------------------------------------------------------------
  wire [1:0]    pin_lvl;
  wire          go_lvl     = pin_lvl[0];
  wire          launch_lvl = pin_lvl[1];
  reg           launch_prev_r;

  link_pin_sync #(
    .WIDTH     (2)
  ) u_pin_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    ({launch_in, go_in}),
    .level_out (pin_lvl)
  );

  // ----------------------------------------------------------------
  // launch detection and local start
  // ----------------------------------------------------------------
  reg  [2:0]    state_r;
  reg  [2:0]    state_nxt;
  reg  [4:0]    space_r;
  reg  [4:0]    space_nxt;
  reg           drive_low_nxt;
  reg           local_go;
  wire          launch_fall;
  wire          start;
  reg           run_r;
  reg           hold_r;
  reg  [TW:0]   tcnt_r;
  reg  [4:0]    hold_cnt_r;

  assign launch_fall = link_en && launch_prev_r && !launch_lvl;
  assign start = link_en ? launch_fall : local_go;

  // ----------------------------------------------------------------
  // leader and local-cycle sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_nxt     = state_r;
    space_nxt     = (space_r != 5'h0) ? space_r - 5'h1 : 5'h0;
    drive_low_nxt = 1'b0;
    local_go      = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (!link_en) begin
          if (local_ready && !run_r && !hold_r) begin
            local_go  = 1'b1;
            space_nxt = SPACE_CYC - 5'h1;
            state_nxt = ST_LOCAL;
          end
        end else if (leader && local_ready && go_lvl && !hold_r) begin
          // confirmed go high: one falling edge
          drive_low_nxt = 1'b1;
          space_nxt     = SPACE_CYC - 5'h1;
          state_nxt     = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        if (space_r > SPACE_CYC - LOW_CYC) begin
          drive_low_nxt = 1'b1;
        end else begin
          state_nxt = ST_SPACE;
        end
      end
      ST_SPACE: begin
        if (space_r == 5'h0) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_LOCAL: begin
        if (space_r == 5'h0) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= ST_IDLE;
      space_r    <= 5'h0;
      launch_out <= 1'b1;
      launch_oe  <= 1'b0;
      launch_prev_r <= 1'b1;
    end else begin
      launch_prev_r <= launch_lvl;
      state_r    <= state_nxt;
      space_r    <= space_nxt;
      launch_out <= !drive_low_nxt;
      launch_oe  <= link_en && leader;
    end
  end

  // ----------------------------------------------------------------
  // readiness hold after cycle start
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      hold_r     <= 1'b0;
      hold_cnt_r <= 5'h0;
    end else if (start) begin
      hold_r     <= 1'b1;
      hold_cnt_r <= SPACE_CYC - 5'h1;
    end else begin
      if (hold_cnt_r != 5'h0) begin
        hold_cnt_r <= hold_cnt_r - 5'h1;
      end
      if (hold_r && hold_cnt_r == 5'h0 && !run_r && local_ready) begin
        hold_r <= 1'b0;
      end
    end
  end

  // open drain: pull low while not ready or holding
  assign go_oe  = link_en && (!local_ready || hold_r);
  assign go_out = 1'b0;

  // ----------------------------------------------------------------
  // strobe and camera trigger timers
  // ----------------------------------------------------------------
  wire [TW:0]   sd = {1'b0, strobe_tm_r[`TIMING_DELAY_LSB +: TW]};
  wire [TW:0]   sw = {1'b0, strobe_tm_r[`TIMING_WIDTH_LSB +: TW]};
  wire [TW:0]   td = {1'b0, trig_tm_r[`TIMING_DELAY_LSB +: TW]};
  wire [TW:0]   tw = {1'b0, trig_tm_r[`TIMING_WIDTH_LSB +: TW]};
  wire [TW+1:0] s_end = {1'b0, sd} + {1'b0, sw};
  wire [TW+1:0] t_end = {1'b0, td} + {1'b0, tw};
  wire [TW+1:0] tcnt_x = {1'b0, tcnt_r};
  wire          s_on = run_r && tcnt_r >= sd && tcnt_x < s_end;
  wire          t_on = run_r && tcnt_r >= td && tcnt_x < t_end;

  always @(posedge aclk) begin
    if (!aresetn) begin
      run_r           <= 1'b0;
      tcnt_r          <= {(TW+1){1'b0}};
      strobe_out      <= 1'b0;
      cam_trigger_out <= 1'b0;
      cycle_start     <= 1'b0;
      cycle_cnt_r     <= 16'h0;
    end else begin
      cycle_start     <= start;
      strobe_out      <= s_on;
      cam_trigger_out <= t_on;
      if (start) begin
        run_r       <= 1'b1;
        tcnt_r      <= {(TW+1){1'b0}};
        cycle_cnt_r <= cycle_cnt_r + 16'h1;
      end else if (run_r) begin
        if (tcnt_x + 1'b1 >= s_end && tcnt_x + 1'b1 >= t_end) begin
          run_r <= 1'b0;
        end
        tcnt_r <= tcnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  wire [3:0]    rd_addr = {s_axi_araddr[3:2], 2'h0};
  reg  [31:0]   rd_val;
  reg           rd_hit;

  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    case (rd_addr)
      `REG_CTRL: begin
        rd_val[1:0] = ctrl_r;
      end
      `REG_STROBE_TIMING: begin
        rd_val = strobe_tm_r;
      end
      `REG_TRIG_TIMING: begin
        rd_val = trig_tm_r;
      end
      `REG_STATUS: begin
        rd_val[`STAT_GO_BIT]          = go_lvl;
        rd_val[`STAT_LAUNCH_BIT]      = launch_lvl;
        rd_val[`STAT_RUN_BIT]         = run_r;
        rd_val[`STAT_HOLD_BIT]        = hold_r;
        rd_val[`STAT_STATE_LSB +: 3]  = state_r;
        rd_val[`STAT_COUNT_LSB +: 16] = cycle_cnt_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // sync_link_ctrl

// *** test/sync_link_ctrl_asserts.sv ***
/*
  checker for the sync link controller: launch line shape and spacing,
  go line ownership, start pulse, register bus refusal.
  assumes it is bound to sync_link_ctrl and sees one clock domain.
*/
module sync_link_ctrl_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link lines
  input wire logic go_in,
  input wire logic go_out,
  input wire logic go_oe,
  input wire logic launch_out,
  input wire logic launch_oe,
  input wire logic local_ready,
  input wire logic cycle_start,
  // register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // cycles since the last launch edge
  // ----------------------------------------------------------------
  logic [4:0] gap_r;
  always @(posedge aclk)
    if (!aresetn) gap_r <= 5'h1f;
    else if ($fell(launch_out)) gap_r <= 5'h00;
    else if (gap_r != 5'h1f) gap_r <= gap_r + 5'h01;

  sequence launch_pulse_s;
    !launch_out [*4] ##1 launch_out;
  endsequence
  sequence go_low_s;
    !go_in [*8];
  endsequence

  launch_width_a: assert property ($fell(launch_out) |-> launch_pulse_s)
    else $error("launch pulse length wrong");
  launch_gap_a: assert property ($fell(launch_out) |-> gap_r >= 5'h0f)
    else $error("launches too close");
  go_block_a: assert property (go_low_s |=> !$fell(launch_out))
    else $error("launch while go low");
  launch_drive_a: assert property (!launch_out |-> launch_oe)
    else $error("launch low without drive");
  go_open_a: assert property (go_out == 1'b0)
    else $error("go driven high");
  start_pulse_a: assert property (cycle_start |=> !cycle_start)
    else $error("start pulse too long");
  start_hold_a: assert property (cycle_start && launch_oe |-> go_oe [*8])
    else $error("go released after start");
  not_ready_a: assert property ((launch_oe && !local_ready) [*2] |-> go_oe)
    else $error("go free while not ready");
  bus_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
endmodule // sync_link_ctrl_asserts

bind sync_link_ctrl sync_link_ctrl_asserts sync_link_ctrl_asserts_inst (
  .aclk, .aresetn, .go_in, .go_out, .go_oe, .launch_out, .launch_oe,
  .local_ready, .cycle_start, .s_axi_awready, .s_axi_wready, .s_axi_bvalid);

// *** test/sync_follower_model.sv ***
/*
  other controllers on the link: followers that hold go low after a
  launch, and an optional leader; resolves both pulled-up lines.
  assumes the device's enables and one clock.
*/
module sync_follower_model (
  // clock
  input  wire logic       aclk,
  // device side
  input  wire logic       go_oe,
  input  wire logic       launch_oe,
  input  wire logic       launch_out,
  // commands
  input  wire logic       busy,
  input  wire logic       lead,
  input  wire logic [7:0] hold_cyc,
  // resolved lines
  output logic            go_line,
  output logic            launch_line,
  output int              n_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hold_r = 8'h00;
  logic [4:0] drv_r  = 5'h00;
  logic [2:0] hi_r   = 3'h0;
  logic       last_r = 1'b1;
  initial n_seen = 0;
  // wired-and with pull-up
  assign go_line = !(go_oe || busy || hold_r != 8'h00);
  assign launch_line = (launch_oe ? launch_out : 1'b1) && !(drv_r > 5'h0c);
  always @(posedge aclk) begin
    last_r <= launch_line;
    hi_r   <= !go_line ? 3'h0 : (hi_r == 3'h7 ? hi_r : hi_r + 3'h1);
    if (last_r && !launch_line) begin
      n_seen <= n_seen + 1;
      hold_r <= hold_cyc;
    end else if (hold_r != 8'h00)
      hold_r <= hold_r - 8'h01;
    if (lead && hi_r == 3'h7 && drv_r == 5'h00) drv_r <= 5'h10;
    else if (drv_r != 5'h00) drv_r <= drv_r - 5'h01;
  end
endmodule // sync_follower_model

// *** test/illumination_controller_sync_link_bench.sv ***
/*
  bench for the sync link controller: registers, disabled, leader
  and follower runs against the follower model.
  assumes the design loops its launch line back through the model.
*/
module illumination_controller_sync_link_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        local_ready = 0, busy = 0, lead = 0;
  logic [7:0]  hold_cyc = 8'h00;
  logic        go_out, go_oe, launch_out, launch_oe, go_line, launch_line;
  logic        strobe_out, cam_trigger_out, cycle_start;
  int          n_fail = 0, samples_checked = 0, n_seen, n_start = 0;
  int          t = 99, dly [2], wid [2], hi [2] = '{0, 0};
  wire [1:0]   pulse = {cam_trigger_out, strobe_out};

  always #12.5 aclk = !aclk;

  sync_link_ctrl sync_link_ctrl_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .local_ready, .go_in(go_line), .go_out,
    .go_oe, .launch_in(launch_line), .launch_out, .launch_oe, .strobe_out,
    .cam_trigger_out, .cycle_start);

  sync_follower_model sync_follower_model_inst (
    .aclk, .go_oe, .launch_oe, .launch_out, .busy, .lead, .hold_cyc,
    .go_line, .launch_line, .n_seen);

  // ----------------------------------------------------------------
  // report
  // ----------------------------------------------------------------
  task automatic check(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic complete_run;
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic time_out;
    check(1'b0, "handshake timeout");
    complete_run();
  endtask

  // ----------------------------------------------------------------
  // pulse timing from each start
  // ----------------------------------------------------------------
  always @(posedge aclk) if (aresetn) begin
    t <= cycle_start ? 1 : t + 1;
    if (cycle_start) n_start <= n_start + 1;
    for (int i = 0; i < 2; i++) begin
      if (pulse[i] && hi[i] == 0)
        check((cycle_start ? 0 : t) === dly[i] + 1, "pulse delay");
      if (!pulse[i] && hi[i] != 0)
        check(hi[i] === wid[i], "pulse width");
      hi[i] <= pulse[i] ? hi[i] + 1 : 0;
    end
  end

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    logic [1:0] br;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        check(br === 2'h0, "write response");
        return;
      end
    end
    time_out();
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    logic ta, tr;
    logic [1:0] rr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) begin
        s_axi_rready <= 1'b0;
        check(rr === 2'h0, "read response");
        return;
      end
    end
    time_out();
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    int s0, st0;
    v = $urandom(82);
    dly[0] = 0;
    wid[0] = $urandom_range(20, 1);
    dly[1] = $urandom_range(20, 0);
    wid[1] = $urandom_range(20, 1);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    hold_cyc <= 8'($urandom_range(40, 0));
    axi_rd(4'h0, v);
    check(v[1:0] === 2'h0, "ctrl reset");
    for (int i = 0; i < 2; i++) begin
      axi_rd(4'(4 + 4 * i), v);
      check(v === 32'h0004_0000, "timing reset");
      axi_wr(4'(4 + 4 * i), {16'(wid[i]), 16'(dly[i])});
      axi_rd(4'(4 + 4 * i), v);
      check(v === {16'(wid[i]), 16'(dly[i])}, "timing readback");
    end
    axi_wr(4'hc, 32'hffff_ffff);
    // disabled link ignores the other leader's launches
    lead <= 1'b1;
    repeat (100) @(posedge aclk);
    @(negedge aclk);
    check(n_start === 0 && n_seen > 0, "start while disabled");
    check(go_oe === 1'b0 && launch_oe === 1'b0, "link driven");
    @(posedge aclk);
    local_ready <= 1'b1;
    repeat (200) @(posedge aclk);
    check(n_start > 1, "independent cycles");
    // leader: followers busy, then slow followers
    lead <= 1'b0;
    busy <= 1'b1;
    axi_wr(4'h0, 32'h0000_0003);
    repeat (60) @(posedge aclk);
    s0 = n_seen;
    st0 = n_start;
    repeat (150) @(posedge aclk);
    check(n_seen === s0, "launch while not ready");
    busy <= 1'b0;
    repeat (300) @(posedge aclk);
    busy <= 1'b1;
    repeat (60) @(posedge aclk);
    check(n_seen - s0 > 1, "no leader launch");
    check(n_start - st0 === n_seen - s0, "leader starts");
    busy <= 1'b0;
    local_ready <= 1'b0;
    s0 = n_seen;
    repeat (100) @(posedge aclk);
    @(negedge aclk);
    check(go_oe === 1'b1 && n_seen === s0, "own readiness");
    // follower under the model leader
    axi_wr(4'h0, 32'h0000_0001);
    local_ready <= 1'b1;
    lead <= 1'b1;
    s0 = n_seen;
    st0 = n_start;
    repeat (300) @(posedge aclk);
    lead <= 1'b0;
    repeat (60) @(posedge aclk);
    check(n_seen - s0 > 1, "no launches");
    check(n_start - st0 === n_seen - s0, "follower starts");
    check(launch_oe === 1'b0, "follower drives launch");
    // second reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(4'h0, v);
    check(v[1:0] === 2'h0 && go_oe === 1'b0, "ctrl after reset");
    complete_run();
  end
endmodule // illumination_controller_sync_link_bench
